/* File: include/spi_port_pkg.sv */
// constants and types shared by the serial peripheral port
package spi_port_pkg;
	localparam int CHAR_BITS      = 8;
	localparam int FIFO_DEPTH     = 4;
	localparam int DIV_WIDTH      = 8;
	localparam logic [7:0] DIV_RESET = 8'h04;
	localparam logic [7:0] CHAR_RESET = 8'h00;
	localparam int SYS_CLK_HZ     = 10000000;
	localparam int SYNC_STAGES    = 2;

	typedef enum logic [1:0] {
		st_idle,
		st_shift,
		st_done
	} master_state_type;
endpackage

/* File: logic/spi_fifo.sv */
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
module spi_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             clk_sys,   // system clock
	input  wire logic             rstn,      // async reset, active low
	input  wire logic [WIDTH-1:0] in_data,   // write data
	input  wire logic             in_valid,  // write request
	output logic                  in_ready,  // not full
	output logic      [WIDTH-1:0] out_data,  // head word
	output logic                  out_valid, // not empty
	input  wire logic             out_ready  // consumer takes head
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_count;
	logic             push;
	logic             pop;
	logic             next_in_ready;

	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1)
			: wr_ptr;
		next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1)
			: rd_ptr;
		next_count = count + (AW+1)'(push) - (AW+1)'(pop);
		// registered so the full flag leaves the port straight from a flop
		next_in_ready = (next_count != (AW+1)'(DEPTH));
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
			in_ready <= 1'b1;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
			in_ready <= next_in_ready;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];
endmodule // spi_fifo

/* File: logic/spi_multi_master_port.sv */
// serial peripheral port with master/slave modes and collision detect
// Contract
// [RULE1] The port moves whole characters full duplex over clock, out data, in data and select.
// [RULE2] One shift register serves transmit and receive, fed by a clock divider and a control unit.
// [RULE3] On a shared bus every serial pin is driven open-drain so two drivers never fight.
// [RULE4] Only one master is active at a time and it selects one slave by pulling its select low.
// [RULE5] As master the port drives serial clock and master-out data toward all slaves.
// [RULE6] As the selected slave the port drives master-in data, and only the selected slave does.
// [RULE7] A master whose select pin is an input sets the collision flag when that pin goes low.
// [RULE8] Slave operation is entered with port_on 1, master_select 0 and select_pin_direction 0.
// [RULE9] A deselected slave ignores clock and data and leaves master-in undriven.
`timescale 1ns/1ns
module spi_multi_master_port
	import spi_port_pkg::*;
#(
	parameter int                 WIDTH = CHAR_BITS,
	parameter int                 DEPTH = FIFO_DEPTH,
	parameter logic [DIV_WIDTH-1:0] DIV_DEFAULT = DIV_RESET
) (
	input  wire logic                 clk_sys,              // 10 MHz clock
	input  wire logic                 rstn,                 // async reset
	input  wire logic                 port_on,              // port enable
	input  wire logic                 master_select,        // 1 master
	input  wire logic                 select_pin_direction, // 1 ss output
	input  wire logic                 clk_phase,            // sample edge
	input  wire logic                 open_drain,           // shared bus
	input  wire logic [DIV_WIDTH-1:0] baud_div,             // half period
	input  wire logic [WIDTH-1:0]     tx_data,              // char to send
	input  wire logic                 tx_valid,             // char offered
	output logic                      tx_ready,             // fifo space
	output logic      [WIDTH-1:0]     rx_data,              // char received
	output logic                      rx_valid,             // one pulse
	input  wire logic                 collision_clear,      // clear flag
	output logic                      collision,            // mode fault
	output logic                      busy,                 // shifting
	output logic                      slave_mode,           // slave active
	input  wire logic                 sck_in,               // clock pin
	output logic                      sck_out,              // clock drive
	output logic                      sck_oe_n,             // low drives
	input  wire logic                 mosi_in,              // mosi pin
	output logic                      mosi_out,             // mosi drive
	output logic                      mosi_oe_n,            // low drives
	input  wire logic                 miso_in,              // miso pin
	output logic                      miso_out,             // miso drive
	output logic                      miso_oe_n,            // low drives
	input  wire logic                 ss_in,                // select pin
	output logic                      ss_out,               // select drive
	output logic                      ss_oe_n               // low drives
);
	localparam int CW = $clog2(WIDTH + 1);

	// pin synchronisers: stage a is read only by stage b
	logic [3:0] sync_a;
	logic [3:0] sync_b;
	logic [3:0] sync_c;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sync_a <= 4'hF;
			sync_b <= 4'hF;
			sync_c <= 4'hF;
		end else begin
			sync_a <= {ss_in, sck_in, mosi_in, miso_in};
			sync_b <= sync_a;
			sync_c <= sync_b;
		end
	end
	logic ss_s, sck_s, mosi_s, miso_s, sck_d;
	assign {ss_s, sck_s, mosi_s, miso_s} = sync_b;
	assign sck_d = sync_c[2];

	logic is_master, is_slave, slave_sel;
	assign is_master = port_on && master_select;
	assign is_slave  = port_on && !master_select && !select_pin_direction; // see [RULE8]
	assign slave_sel = is_slave && !ss_s; // see [RULE9]

	// transmit buffer
	logic [WIDTH-1:0] fifo_data;
	logic             fifo_valid;
	logic             fifo_pop;
	spi_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_txq (
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.in_data   (tx_data),
		.in_valid  (tx_valid),
		.in_ready  (tx_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop)
	);

	master_state_type state, next_state;
	logic [WIDTH-1:0]     shreg, next_shreg;         // see [RULE2]
	logic [CW-1:0]        bitcnt, next_bitcnt;
	logic [DIV_WIDTH-1:0] divcnt, next_divcnt;
	logic                 sck_q, next_sck_q;
	logic                 mosi_q, next_mosi_q;
	logic                 miso_q, next_miso_q;
	logic                 ssq, next_ssq;
	logic                 col, next_col;
	logic                 rxv, next_rxv;
	logic [WIDTH-1:0]     rxd, next_rxd;
	logic                 smode, next_smode;
	logic                 tick;
	logic                 next_busy;

	// one-cycle enable from the divider gives the serial half period
	assign tick = (divcnt == '0);

	always_comb begin
		next_state  = state;
		next_shreg  = shreg;
		next_bitcnt = bitcnt;
		next_divcnt = (tick || state == st_idle) ? baud_div : divcnt - 1'b1;
		next_sck_q  = sck_q;
		next_mosi_q = mosi_q;
		next_miso_q = miso_q;
		next_ssq    = 1'b1;
		next_col    = col;
		next_rxv    = 1'b0;
		next_rxd    = rxd;
		next_smode  = is_slave;
		fifo_pop    = 1'b0;
		// set wins over clear
		if (collision_clear)
			next_col = 1'b0;
		if (is_master && !select_pin_direction && !ss_s)
			next_col = 1'b1; // see [RULE7]
		unique case (state)
		st_idle: begin
			next_sck_q = 1'b0;
			next_bitcnt = '0;
			if (is_master && fifo_valid && !next_col) begin
				fifo_pop = 1'b1;
				next_shreg = fifo_data;
				next_mosi_q = fifo_data[WIDTH-1];
				next_state = st_shift;
			end else if (slave_sel) begin
				next_shreg = fifo_valid ? fifo_data : CHAR_RESET;
				fifo_pop = fifo_valid;
				next_miso_q = fifo_valid ? fifo_data[WIDTH-1] : 1'b0;
				next_state = st_shift;
			end
		end
		st_shift: begin
			if (is_master) begin
				next_ssq = select_pin_direction ? 1'b0 : 1'b1; // see [RULE4]
				if (next_col) begin
					next_state = st_idle; // fault aborts the character
				end else if (tick) begin
					next_sck_q = !sck_q; // see [RULE5]
					if (sck_q == clk_phase) begin
						next_shreg = {shreg[WIDTH-2:0], miso_s}; // see [RULE1]
						next_bitcnt = bitcnt + 1'b1;
					end else if (bitcnt != '0) begin
						next_mosi_q = shreg[WIDTH-1];
					end
					// judge on the updated count, so phase 1 stops at its 8th sample
					if (sck_q && next_bitcnt == CW'(WIDTH))
						next_state = st_done;
				end
			end else if (slave_sel) begin
				if (sck_s != sck_d) begin
					if (sck_s != clk_phase) begin
						next_shreg = {shreg[WIDTH-2:0], mosi_s}; // see [RULE1]
						next_bitcnt = bitcnt + 1'b1;
						if (bitcnt == CW'(WIDTH - 1))
							next_state = st_done;
					end else if (bitcnt != '0) begin
						next_miso_q = shreg[WIDTH-1]; // see [RULE6]
					end
				end
			end else begin
				next_state = st_idle; // see [RULE9]
			end
		end
		st_done: begin
			next_rxv = 1'b1;
			next_rxd = shreg;
			next_sck_q = 1'b0;
			next_state = st_idle;
		end
		endcase
		next_busy = (next_state != st_idle);
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state  <= st_idle;
			shreg  <= CHAR_RESET;
			bitcnt <= '0;
			divcnt <= DIV_DEFAULT;
			sck_q  <= 1'b0;
			mosi_q <= 1'b0;
			miso_q <= 1'b0;
			ssq    <= 1'b1;
			col    <= 1'b0;
			rxv    <= 1'b0;
			rxd    <= CHAR_RESET;
			smode  <= 1'b0;
			busy   <= 1'b0;
		end else begin
			state  <= next_state;
			shreg  <= next_shreg;
			bitcnt <= next_bitcnt;
			divcnt <= next_divcnt;
			sck_q  <= next_sck_q;
			mosi_q <= next_mosi_q;
			miso_q <= next_miso_q;
			ssq    <= next_ssq;
			col    <= next_col;
			rxv    <= next_rxv;
			rxd    <= next_rxd;
			smode  <= next_smode;
			busy   <= next_busy;
		end
	end

	// pin drivers; open drain only ever pulls low, a one is released
	logic sck_en, mosi_en, miso_en, ss_en;
	logic next_sck_oe_n, next_mosi_oe_n, next_miso_oe_n, next_ss_oe_n;
	always_comb begin
		sck_en  = is_master;                                  // see [RULE5]
		mosi_en = is_master;
		miso_en = slave_sel && state != st_idle;              // see [RULE6]
		ss_en   = is_master && select_pin_direction;          // see [RULE4]
		next_sck_oe_n  = !(sck_en && !(open_drain && next_sck_q));  // see [RULE3]
		next_mosi_oe_n = !(mosi_en && !(open_drain && next_mosi_q));
		next_miso_oe_n = !(miso_en && !(open_drain && next_miso_q));
		next_ss_oe_n   = !(ss_en && !(open_drain && next_ssq));
	end
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sck_oe_n  <= 1'b1;
			mosi_oe_n <= 1'b1;
			miso_oe_n <= 1'b1;
			ss_oe_n   <= 1'b1;
		end else begin
			sck_oe_n  <= next_sck_oe_n;
			mosi_oe_n <= next_mosi_oe_n;
			miso_oe_n <= next_miso_oe_n;
			ss_oe_n   <= next_ss_oe_n;
		end
	end

	assign sck_out    = sck_q;
	assign mosi_out   = mosi_q;
	assign miso_out   = miso_q;
	assign ss_out     = ssq;
	assign collision  = col;
	assign rx_valid   = rxv;
	assign rx_data    = rxd;
	assign slave_mode = smode;
endmodule // spi_multi_master_port

/* File: verif/spi_port_sva.sv */
// concurrent checks on the serial port's pins and flags
`timescale 1ns/1ns
module spi_port_sva (
	input wire logic clk_sys,              // clock
	input wire logic rstn,                 // reset
	input wire logic port_on,              // enable
	input wire logic master_select,        // master
	input wire logic select_pin_direction, // ss dir
	input wire logic open_drain,           // shared bus
	input wire logic collision_clear,      // clear
	input wire logic collision,            // fault
	input wire logic slave_mode,           // slave
	input wire logic rx_valid,             // rx pulse
	input wire logic ss_in,                // select
	input wire logic sck_out,              // sck drive
	input wire logic sck_oe_n,             // sck enable
	input wire logic mosi_out,             // mosi drive
	input wire logic mosi_oe_n,            // mosi enable
	input wire logic miso_oe_n             // miso enable
);
	wire cfg_slave = port_on & ~master_select & ~select_pin_direction;
	wire cfg_fault = port_on & master_select & ~select_pin_direction & ~ss_in;
	default clocking dck @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	a_slave_entry:
		assert property (cfg_slave [*3] |-> slave_mode) else $error("no slave");
	a_slave_quiet:
		assert property (slave_mode |-> sck_oe_n && mosi_oe_n)
		else $error("slave drives sck");
	// select passes a two-stage sync, so allow a few cycles to let go
	a_deselect_quiet:
		assert property ((slave_mode && ss_in) [*5] |-> miso_oe_n)
		else $error("miso while deselected");
	a_master_miso:
		assert property (master_select [*3] |-> miso_oe_n) else $error("miso");
	a_od_release:
		assert property (open_drain && $past(open_drain) |->
			(sck_oe_n || !sck_out) && (mosi_oe_n || !mosi_out))
		else $error("high driven");
	a_fault_set:
		assert property (cfg_fault [*4] |-> collision) else $error("no fault");
	a_fault_hold:
		assert property (collision && !collision_clear |=> collision)
		else $error("fault lost");
	a_rx_pulse:
		assert property (rx_valid |=> !rx_valid) else $error("long rx pulse");
endmodule // spi_port_sva

bind spi_multi_master_port spi_port_sva spi_port_sva_i (.*);

/* File: verif/spi_far_end.sv */
// far side: loopback slave, second master, select and clock driver
`timescale 1ns/1ns
module spi_far_end (
	input  wire logic mosi_in,  // shared mosi
	output logic      sck_drv,  // 0 pulls sck
	output logic      mosi_drv, // 0 pulls mosi
	output logic      miso_drv, // 0 pulls miso
	output logic      ss_drv    // 0 pulls select
);
	logic loop = 1'b1;
	// only ever pulls low; a one is a release to the pull-up
	assign miso_drv = loop ? mosi_in : 1'b1;
	initial {sck_drv, mosi_drv, ss_drv} <= 3'h7;
	// bus at rest with loopback on; sel 1 pulls the port's select low
	task automatic rest(input logic sel);
		loop <= 1'b1;
		ss_drv <= ~sel;
	endtask
	// acts as the only master: loopback off so miso is left to the port
	task automatic frame(input logic [7:0] b, input logic sel);
		loop <= 1'b0;
		ss_drv <= ~sel;
		#400;
		for (int i = 7; i >= 0; i--) begin
			mosi_drv <= b[i];
			#400 sck_drv <= 1'b0;
			#400 sck_drv <= 1'b1;
			#400;
		end
		{ss_drv, mosi_drv} <= 2'h3;
	endtask
endmodule // spi_far_end

/* File: verif/testbench.sv */
// self-checking bench for the serial peripheral port
`timescale 1ns/1ns
module testbench;
	// row is {open drain, phase, sent, expected}; far end loops mosi to miso
	logic [17:0] rows [6] = '{{1'b1, 1'b0, 8'hA5, 8'hA5},
		{1'b1, 1'b1, 8'h5A, 8'h5A}, {1'b0, 1'b0, 8'h3C, 8'h3C},
		{1'b0, 1'b1, 8'hC3, 8'hC3}, {1'b1, 1'b0, 8'h00, 8'h00},
		{1'b1, 1'b1, 8'hFF, 8'hFF}};
	logic        clk_sys = 1'b0, rstn = 1'b0, port_on = 1'b1;
	logic        open_drain = 1'b1, master_select = 1'b1, clk_phase = 1'b0;
	logic        select_pin_direction = 1'b1, tx_valid = 1'b0;
	logic        collision_clear = 1'b0, miso_drove, tx_ready, rx_valid;
	logic [7:0]  baud_div = 8'h03, tx_data = 8'h00, rx_data, rxq [$];
	logic        collision, busy, slave_mode, sck_out, sck_oe_n, mosi_out;
	logic        mosi_oe_n, miso_out, miso_oe_n, ss_out, ss_oe_n;
	logic        sck_drv, mosi_drv, miso_drv, ss_drv;
	int          errors, checked;
	wire         sck_in = (sck_oe_n | sck_out) & sck_drv;
	wire         mosi_in = (mosi_oe_n | mosi_out) & mosi_drv;
	wire         miso_in = (miso_oe_n | miso_out) & miso_drv;
	wire         ss_in = (ss_oe_n | ss_out) & ss_drv;
	wire [7:0]   idle_pins = {sck_oe_n, mosi_oe_n, miso_oe_n, ss_oe_n, ss_out,
		tx_ready, busy, collision};
	spi_multi_master_port spi_multi_master_port_i (.*);
	spi_far_end spi_far_end_i (.*);
	initial forever #50 clk_sys = ~clk_sys;
	initial begin
		#1000000 errors++;
		results();
	end
	always @(posedge clk_sys) if (rx_valid === 1'b1) rxq.push_back(rx_data);
	always @(posedge clk_sys) miso_drove <= miso_drove | (miso_oe_n === 1'b0);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// leaves tx_valid up so back-to-back pushes never drop it between words
	task automatic push(input logic [7:0] d);
		tx_data <= d;
		tx_valid <= 1'b1;
		do @(negedge clk_sys); while (tx_ready !== 1'b1);
		@(posedge clk_sys);
	endtask
	task automatic pop(input logic [7:0] exp);
		for (int n = 0; n < 300 && rxq.size() == 0; n++) @(posedge clk_sys);
		chk(rxq.size() > 0 ? rxq.pop_front() : 8'hXX, exp);
	endtask
	task automatic results();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		foreach (rows[i]) begin
			{open_drain, clk_phase} <= rows[i][17:16];
			push(rows[i][15:8]);
			tx_valid <= 1'b0;
			pop(rows[i][7:0]);
		end
		$display("loopback rows done");
		select_pin_direction <= 1'b0;
		spi_far_end_i.rest(1'b1);
		repeat (6) @(negedge clk_sys);
		chk({7'h00, collision}, 8'h01);
		@(posedge clk_sys);
		for (int i = 0; i < 4; i++) push(8'h10 + 8'(i));
		repeat (3) @(negedge clk_sys);
		chk({7'h00, tx_ready}, 8'h00);
		@(posedge clk_sys);
		tx_valid <= 1'b0;
		spi_far_end_i.rest(1'b0);
		collision_clear <= 1'b1;
		repeat (4) @(posedge clk_sys);
		collision_clear <= 1'b0;
		@(negedge clk_sys);
		chk({7'h00, collision}, 8'h00);
		for (int i = 0; i < 4; i++) pop(8'h10 + 8'(i));
		$display("collision and fifo test done");
		master_select <= 1'b0;
		repeat (4) @(negedge clk_sys);
		chk({7'h00, slave_mode}, 8'h01);
		miso_drove = 1'b0;
		spi_far_end_i.frame(8'hC3, 1'b1);
		pop(8'hC3);
		chk({7'h00, miso_drove}, 8'h01);
		repeat (6) @(negedge clk_sys);
		miso_drove = 1'b0;
		spi_far_end_i.frame(8'h3C, 1'b0);
		repeat (20) @(posedge clk_sys);
		chk(8'(rxq.size()), 8'h00);
		chk({7'h00, miso_drove}, 8'h00);
		$display("slave test done");
		// reset in the middle of a master character must abort it cleanly
		spi_far_end_i.rest(1'b0);
		master_select <= 1'b1;
		select_pin_direction <= 1'b1;
		push(8'h96);
		tx_valid <= 1'b0;
		repeat (10) @(negedge clk_sys);
		chk({7'h00, busy}, 8'h01);
		@(posedge clk_sys);
		rstn <= 1'b0;
		@(negedge clk_sys);
		chk(idle_pins, 8'hFC);
		@(posedge clk_sys);
		rstn <= 1'b1;
		repeat (100) @(posedge clk_sys);
		chk(8'(rxq.size()), 8'h00);
		push(8'h69);
		tx_valid <= 1'b0;
		pop(8'h69);
		$display("reset test done");
		results();
	end
endmodule // testbench
